// [acmp_ctrl.sv]
`include "acmp_regs.svh"

// Operation
// [R1] control bit 30 reads the output level after polarity
// [R2] bit 15 inverts the comparator output before all later use; inversion comes after the glitch filter, which sees the uninverted level
// [R3] bit 11 ties the first unit positive input to the second unit's
// [R4] bit 5 picks which of two pins is the negative input
// [R5] bit 0 switches the comparator on, off after reset
// [R6] bits 25:22 set reference to (n+1)/16, reset value 0111
// [R7] bit 27 picks buffered reference or supply as source
// [R8] bit 26 enables divider, and bandgap when source is buffered
// [R9] configuration registers run on the bus clock
// [R10] latch and filter sample on bus, crystal or internal low clock; only the enabled filter follows it, the output latch runs on pclk
// [R11] software picks a low-speed clock to keep working in stop
// [R12] bus reset returns all configuration fields to reset values
// [R13] software reset clears output latch and filter
// [R14] enabled filter drops pulses shorter than the filter length
// [R15] disabled filter passes its input straight through
// [R16] software sets up the filter before switching the unit on
// [R17] output drives its own event controller line
// [R18] comparator keeps running in sleep and stop, wakes the device
// [R19] software puts comparator input pins into analog mode
// [R20] output routed to timer break, ref clear, capture and a pin
// [R21] filter output changes only after samples stayed steady for count
// [R22] comparator level passes a two-stage synchroniser before use
module acmp_ctrl
  import acmp_pkg::*;
(
  // apb slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // analog core and low-speed clocks
  input wire logic cmp_raw,
  input wire logic low_speed_crystal_clock,
  input wire logic low_speed_internal_clock,
  output acmp_ana_s ana,
  // conditioned output routes
  output acmp_route_s route
);

  acmp_state_s s_q;
  acmp_state_s s_d;

  logic setup;
  logic wr;
  logic tick;
  logic cond;
  logic soft_rst;

  always_comb begin
    s_d = s_q;
    setup = psel && !penable && !s_q.pready;
    wr = psel && penable && s_q.pready && pwrite;
    soft_rst = 1'b0;

    // zero wait state: ready comes one cycle after setup
    s_d.pready = setup;
    s_d.pslverr = 1'b0;
    if (setup) begin
      s_d.prdata = 32'h0000_0000;
      unique case (paddr)
        `ACMP_CTRL_OFS: begin
          s_d.prdata[`ACMP_ON_BIT] = s_q.ana.unit_on;
          s_d.prdata[`ACMP_NSEL_BIT] = s_q.ana.negative_input_choice;
          s_d.prdata[`ACMP_WIN_BIT] = s_q.ana.pos_from_second;
          s_d.prdata[`ACMP_POL_BIT] = s_q.pol;
          s_d.prdata[`ACMP_DIV_MSB:`ACMP_DIV_LSB] = s_q.ana.ref_divider_ratio;
          s_d.prdata[`ACMP_DIVON_BIT] = s_q.ana.ref_divider_on;
          s_d.prdata[`ACMP_SRC_BIT] = s_q.ana.ref_source_select;
          s_d.prdata[`ACMP_RES_BIT] = s_q.result; // [R1]
        end
        `ACMP_FILT_OFS: begin
          s_d.prdata[`ACMP_FEN_BIT] = s_q.flt_en;
          s_d.prdata[`ACMP_FLEN_MSB:`ACMP_FLEN_LSB] = s_q.flt_len;
        end
        `ACMP_CLKR_OFS: begin
          s_d.prdata[`ACMP_CSEL_MSB:`ACMP_CSEL_LSB] = s_q.ck_sel;
        end
        default: begin
          s_d.pslverr = 1'b1;
        end
      endcase
    end else begin
      s_d.pslverr = s_q.pslverr && !s_q.pready;
    end

    // writes land at the access edge only; registers sit on pclk [R9]
    if (wr) begin
      unique case (paddr)
        `ACMP_CTRL_OFS: begin
          s_d.ana.unit_on = pwdata[`ACMP_ON_BIT]; // [R5]
          s_d.ana.negative_input_choice = pwdata[`ACMP_NSEL_BIT]; // [R4]
          s_d.ana.pos_from_second = pwdata[`ACMP_WIN_BIT]; // [R3]
          s_d.pol = pwdata[`ACMP_POL_BIT]; // [R2]
          s_d.ana.ref_divider_ratio = pwdata[`ACMP_DIV_MSB:`ACMP_DIV_LSB]; // [R6]
          s_d.ana.ref_divider_on = pwdata[`ACMP_DIVON_BIT]; // [R8]
          s_d.ana.ref_source_select = pwdata[`ACMP_SRC_BIT]; // [R7]
        end
        `ACMP_FILT_OFS: begin
          // no lockout while on: retuning a live filter may glitch once [R16]
          s_d.flt_en = pwdata[`ACMP_FEN_BIT];
          s_d.flt_len = pwdata[`ACMP_FLEN_MSB:`ACMP_FLEN_LSB];
        end
        `ACMP_CLKR_OFS: begin
          s_d.ck_sel = acmp_ck_e'(pwdata[`ACMP_CSEL_MSB:`ACMP_CSEL_LSB]);
          soft_rst = pwdata[`ACMP_SRST_BIT];
        end
        default: begin
        end
      endcase
    end

    // bandgap follows the divider only on the buffered source [R8]
    s_d.ana.bandgap_on = s_d.ana.ref_divider_on && !s_d.ana.ref_source_select;
    // supply as source leaves the buffered reference unavailable [R7]
    s_d.ana.buffered_ref_avail = !s_d.ana.ref_source_select;

    // raw level is asynchronous, two flops before anyone looks [R22]
    s_d.raw_s1 = cmp_raw;
    s_d.raw_s2 = s_q.raw_s1;
    s_d.lsx_s1 = low_speed_crystal_clock;
    s_d.lsx_s2 = s_q.lsx_s1;
    s_d.lsx_s3 = s_q.lsx_s2;
    s_d.lsi_s1 = low_speed_internal_clock;
    s_d.lsi_s2 = s_q.lsi_s1;
    s_d.lsi_s3 = s_q.lsi_s2;

    // sample tick from the chosen comparator clock [R10]
    unique case (s_q.ck_sel)
      ACMP_CK_BUS: tick = 1'b1;
      ACMP_CK_LSX: tick = s_q.lsx_s2 && !s_q.lsx_s3;
      ACMP_CK_LSI: tick = s_q.lsi_s2 && !s_q.lsi_s3;
      default: tick = 1'b0;
    endcase

    // glitch filter
    if (!s_q.flt_en) begin
      s_d.filt = s_q.raw_s2; // [R15]
      s_d.cnt = 16'h0000;
    end else if (tick) begin
      if (s_q.raw_s2 == s_q.filt) begin
        s_d.cnt = 16'h0000;
      end else if (s_q.cnt + 16'h0001 >= s_q.flt_len) begin
        // changes only after flt_len steady differing samples [R14] [R21]
        s_d.filt = s_q.raw_s2;
        s_d.cnt = 16'h0000;
      end else begin
        s_d.cnt = s_q.cnt + 16'h0001;
      end
    end

    // an off unit shows low so stale levels do not wake anything
    cond = s_q.ana.unit_on && (s_q.filt ^ s_q.pol); // [R2]
    s_d.result = cond; // [R1]
    s_d.route.event_line = cond; // [R17] [R18]
    s_d.route.timer_break = cond; // [R20]
    s_d.route.timer_ocref_clear = cond; // [R20]
    s_d.route.timer_capture = cond; // [R20]
    s_d.route.alt_pin = cond; // [R20]

    // software reset clears only the output path [R13]
    if (soft_rst) begin
      s_d.raw_s1 = 1'b0;
      s_d.raw_s2 = 1'b0;
      s_d.filt = 1'b0;
      s_d.cnt = 16'h0000;
      s_d.result = 1'b0;
      s_d.route = '0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0; // [R12]
      s_q.ana.ref_divider_ratio <= `ACMP_DIV_RST; // [R6]
      s_q.ana.buffered_ref_avail <= 1'b1;
      s_q.flt_len <= `ACMP_FLEN_RST;
      s_q.ck_sel <= ACMP_CK_BUS;
    end else begin
      s_q <= s_d;
    end
  end

  assign prdata = s_q.prdata;
  assign pready = s_q.pready;
  assign pslverr = s_q.pslverr;
  assign ana = s_q.ana;
  assign route = s_q.route;

endmodule

// [acmp_regs.svh]
`ifndef ACMP_REGS_SVH
`define ACMP_REGS_SVH
// register byte offsets
`define ACMP_CTRL_OFS 12'h000
`define ACMP_FILT_OFS 12'h004
`define ACMP_CLKR_OFS 12'h008
// control register fields
`define ACMP_ON_BIT 0
`define ACMP_NSEL_BIT 5
`define ACMP_WIN_BIT 11
`define ACMP_POL_BIT 15
`define ACMP_DIV_LSB 22
`define ACMP_DIV_MSB 25
`define ACMP_DIVON_BIT 26
`define ACMP_SRC_BIT 27
`define ACMP_RES_BIT 30
`define ACMP_DIV_RST 4'h7
// filter register fields
`define ACMP_FEN_BIT 0
`define ACMP_FLEN_LSB 16
`define ACMP_FLEN_MSB 31
`define ACMP_FLEN_RST 16'h0000
// clock and soft reset register fields
`define ACMP_CSEL_LSB 0
`define ACMP_CSEL_MSB 1
`define ACMP_SRST_BIT 8
`define ACMP_CSEL_RST 2'h0
`endif

// [acmp_pkg.sv]
package acmp_pkg;
  // comparator clock source codes
  typedef enum logic [1:0] {
    ACMP_CK_BUS = 2'h0,
    ACMP_CK_LSX = 2'h1,
    ACMP_CK_LSI = 2'h2
  } acmp_ck_e;

  // analog-facing controls
  typedef struct packed {
    logic unit_on;
    logic pos_from_second;
    logic negative_input_choice;
    logic ref_source_select;
    logic ref_divider_on;
    logic [3:0] ref_divider_ratio;
    logic bandgap_on;
    logic buffered_ref_avail;
  } acmp_ana_s;

  // conditioned output routes
  typedef struct packed {
    logic event_line;
    logic timer_break;
    logic timer_ocref_clear;
    logic timer_capture;
    logic alt_pin;
  } acmp_route_s;

  typedef struct packed {
    acmp_ana_s ana;
    logic pol;
    logic flt_en;
    logic [15:0] flt_len;
    acmp_ck_e ck_sel;
    logic raw_s1;
    logic raw_s2;
    logic lsx_s1;
    logic lsx_s2;
    logic lsx_s3;
    logic lsi_s1;
    logic lsi_s2;
    logic lsi_s3;
    logic filt;
    logic [15:0] cnt;
    acmp_route_s route;
    logic result;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } acmp_state_s;
endpackage

// [acmp_ctrl_asserts.sv]
module acmp_ctrl_asserts
  import acmp_pkg::*;
(
  // apb side
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // analog side
  input wire logic cmp_raw,
  input wire logic low_speed_crystal_clock,
  input wire logic low_speed_internal_clock,
  input wire acmp_ana_s ana,
  input wire acmp_route_s route
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup; psel && !penable; endsequence
  sequence s_cwr; psel && penable && pwrite && pready && paddr == 12'h000; endsequence
  sequence s_off2; !ana.unit_on ##1 !ana.unit_on; endsequence
  property p_answer; s_setup |=> pready ##1 !pready; endproperty
  a_answer: assert property (p_answer) else $error("pready not one cycle after setup");
  property p_err; pready && !(paddr inside {12'h000, 12'h004, 12'h008}) |-> pslverr && prdata == 32'h0; endproperty
  a_err: assert property (p_err) else $error("unmapped access not refused");
  property p_lone; pslverr |-> pready; endproperty
  a_lone: assert property (p_lone) else $error("pslverr without pready");
  property p_ctrl;
    s_cwr |=> ana.unit_on == $past(pwdata[0]) && ana.negative_input_choice == $past(pwdata[5])
      && ana.pos_from_second == $past(pwdata[11]) && ana.ref_divider_ratio == $past(pwdata[25:22])
      && ana.ref_divider_on == $past(pwdata[26]) && ana.ref_source_select == $past(pwdata[27]);
  endproperty
  a_ctrl: assert property (p_ctrl) else $error("control write not applied");
  property p_bg; ana.bandgap_on == (ana.ref_divider_on && !ana.ref_source_select); endproperty
  a_bg: assert property (p_bg) else $error("bandgap enable wrong");
  property p_buf; ana.buffered_ref_avail == !ana.ref_source_select; endproperty
  a_buf: assert property (p_buf) else $error("buffered reference availability wrong");
  property p_off; s_off2 |-> route == 5'h00; endproperty
  a_off: assert property (p_off) else $error("output active while unit off");
  property p_routes; route == {5{route.event_line}}; endproperty
  a_routes: assert property (p_routes) else $error("routes disagree");
endmodule

bind acmp_ctrl acmp_ctrl_asserts acmp_ctrl_asserts_inst (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .cmp_raw(cmp_raw),
  .low_speed_crystal_clock(low_speed_crystal_clock),
  .low_speed_internal_clock(low_speed_internal_clock), .ana(ana), .route(route));

// [acmp_partner.sv]
module acmp_partner (
  // commanded comparator level
  input wire logic lvl,
  // towards the design
  output logic cmp_raw,
  output logic xtal_clk,
  output logic slow_clk
);
  timeunit 1ns;
  timeprecision 1ns;
  // slow clocks run free, unrelated to pclk
  initial begin
    xtal_clk = 1'b0;
    forever #230 xtal_clk = ~xtal_clk;
  end
  initial begin
    slow_clk = 1'b0;
    forever #370 slow_clk = ~slow_clk;
  end
  // input pins sit in analog mode, so only a level arrives, off the clock grid
  assign #7 cmp_raw = lvl;
endmodule

// [tb_analog_comparator_control.sv]
module tb_analog_comparator_control import acmp_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, lvl, raw, xtal, slow, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdv, d;
  logic [31:0] msk[3] = '{32'h0fc08821, 32'hffff0001, 32'h00000003};
  acmp_ana_s ana;
  acmp_route_s route;
  int fail_count, n_compared, res;
  int mdl[3];
  acmp_ctrl acmp_ctrl_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cmp_raw(raw), .low_speed_crystal_clock(xtal),
    .low_speed_internal_clock(slow), .ana(ana), .route(route));
  acmp_partner acmp_partner_inst (.lvl(lvl), .cmp_raw(raw), .xtal_clk(xtal), .slow_clk(slow));
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(logic w, logic [11:0] a, logic [31:0] dv);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= dv;
    @(posedge pclk);
    penable <= 1'b1;
    // no wait limit here: the watchdog ends a hung transfer
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (w && a < 12'h00c) mdl[a[3:2]] = int'(dv & msk[a[3:2]]);
  endtask
  task automatic rd(logic [11:0] a);
    bus(1'b0, a, 32'h0);
    chk(rdv, a == 12'h000 ? 32'(mdl[0] | (res << 30)) : 32'(mdl[a[3:2]]));
  endtask
  task automatic rst(int n);
    presetn <= 1'b0;
    repeat (n) @(posedge pclk);
    presetn <= 1'b1;
    mdl = '{32'h01c00000, 0, 0};
    res = 0;
  endtask
  // waits the caller's w pclk cycles, then checks the result bit and all five routes
  task automatic lv(logic v, int w, int e);
    lvl <= v;
    repeat (w) @(posedge pclk);
    res = e;
    rd(12'h000);
    chk(32'(route), e != 0 ? 32'h1f : 32'h0);
  endtask
  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (4000) @(posedge pclk);
    fail_count++;
    results();
  end
  initial begin
    {psel, penable, pwrite, lvl, presetn, paddr, pwdata} = '0;
    fail_count = 0;
    n_compared = 0;
    void'($urandom(23208));
    rst(12);
    for (int i = 0; i < 3; i++) rd(12'(4 * i));
    chk(32'(ana), 32'h01d);
    for (int n = 0; n < 16; n++) begin
      d = ($urandom & 32'h0c008820) | (32'(n) << 22);
      bus(1'b1, 12'h000, d);
      rd(12'h000);
      chk(32'(ana), 32'({d[0], d[11], d[5], d[27], d[26], d[25:22], d[26] & ~d[27], ~d[27]}));
    end
    bus(1'b1, 12'h00c, 32'hffffffff);
    chk({31'h0, err}, 32'h1);
    bus(1'b0, 12'h00c, 32'h0);
    chk(rdv, 32'h0);
    for (int p = 0; p < 2; p++) begin
      bus(1'b1, 12'h000, 32'h1 | 32'(p << 15));
      lv(1'b1, 6, 1 - p);
      lv(1'b0, 6, p);
    end
    // filter set up while the unit is off, then switched on
    bus(1'b1, 12'h000, 32'h0);
    bus(1'b1, 12'h004, 32'h00280001);
    bus(1'b1, 12'h000, 32'h1);
    lv(1'b1, 4, 0);
    lv(1'b0, 4, 0);
    lv(1'b1, 60, 1);
    // level stays high: only the soft reset can drop the output here
    bus(1'b1, 12'h008, 32'h100);
    lv(1'b1, 3, 0);
    rd(12'h008);
    bus(1'b1, 12'h000, 32'h0);
    bus(1'b1, 12'h004, 32'h0);
    bus(1'b1, 12'h000, 32'h1);
    for (int s = 1; s < 3; s++) begin
      bus(1'b1, 12'h008, 32'(s));
      lv(1'b1, 100, 1);
      lv(1'b0, 100, 0);
    end
    bus(1'b1, 12'h000, 32'h0);
    lv(1'b1, 6, 0);
    rst(3);
    for (int i = 0; i < 3; i++) rd(12'(4 * i));
    results();
  end
endmodule
